// ==== core/mac_ctrl_consts.vh ====
// Notes on behaviour
// - copy control frames to memory with control flag when bit 24 set, else drop.
// - short frames under 64 bytes kept when bit 23 set, flagged fragment or undersized.
// - errored frames kept with error flag when bit 22 set, else dropped.
// - pin mode select takes duplex and gigabit from input pins; status shows actual duplex.
// - force gigabit bit puts the mac into gigabit mode.
// - two gasket outputs driven straight from control bits 16 and 15.
// - idle command enters idle, then idle status bit 31 is set.
// - short gap transmit only when bit 10 set and short gap input high.
// - speed bit selects 10/100 at 0, gigabit full duplex only at 1.
// - interface enable low holds receive and transmit logic in reset.
// - pause frames obeyed only in full duplex with transmit flow enable.
// - receive flow enable lets trigger force collisions or send pause frames.
// - backoff and pause timer writes accepted only with manufacturing test set.
// - loopback forces full duplex; change it only while interface disabled.
// - duplex bit selects half/full; gigabit forces full; duplex pin mirrors bit.
// - during pause period no new transmit except pause; running one completes.
// - status shows external speed bit 4, external duplex bit 3, flow active bit 1.
// - soft reset bit resets mac logic, reads 1 until done then 0.
// - frames longer than 11-bit limit are long: oversized if clean, jabber if errored.
// - pacing counter loads 31 on collision/deferral, decrements on clean frames, 4 gaps.
// - random generator resets to zero, counts from reset release, test-mode writable.
// - read-only 4-bit collision tally and 10-bit backoff counter per slot.
`ifndef MAC_CTRL_CONSTS_VH
`define MAC_CTRL_CONSTS_VH
// ==========================================
// register byte offsets
`define OFS_CONTROL 12'h000
`define OFS_STATUS 12'h004
`define OFS_SOFTRST 12'h008
`define OFS_MAXLEN 12'h00c
`define OFS_BOFF 12'h010
// ==========================================
// control fields
`define B_CMF 24
`define B_CSF 23
`define B_CEF 22
`define B_PINSEL 18
`define B_FGIG 17
`define B_IFB 16
`define B_IFA 15
`define B_IDLE 11
`define B_SGAP 10
`define B_GIG 7
`define B_PACE 6
`define B_IFEN 5
`define B_TXFL 4
`define B_RXFL 3
`define B_MANUFACTURING_TEST 2
`define B_LOOP 1
`define B_FDX 0
`define CTRL_MASK 32'h01c78cff
// ==========================================
// status fields
`define S_IDLE 31
`define S_EXTGIG 4
`define S_EXTFDX 3
`define S_RXFA 1
`define S_TXFA 0
// ==========================================
// backoff register fields and values
`define PACE_HI 30
`define PACE_LO 26
`define RND_HI 25
`define RND_LO 16
`define COLL_HI 15
`define COLL_LO 12
`define BO_HI 9
`define BO_LO 0
`define PACE_LOAD 5'h1f
`define MAXLEN_RST 11'h5ee
`define MIN_FRAME 11'h040
`define PACE_GAPS 3'h4
`define BACKOFF_LIMIT 4'ha
`endif

// ==== core/mac_ctrl_status.v ====
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`include "mac_ctrl_consts.vh"
module mac_ctrl_status #(
   parameter SLOT_CYCLES = 512
) (
   input wire core_clk,
   input wire rst,
   input wire clkEn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire duplexIn,
   input wire speedSelectInput,
   input wire externalSpeedState,
   input wire externalDuplexState,
   input wire shortGapIn,
   input wire macIdleAck,
   input wire rxFlowTrigger,
   input wire pauseFrameRx,
   input wire pauseActive,
   input wire pauseTimerWrite,
   input wire txStartReq,
   input wire txIsPause,
   input wire txBusy,
   input wire txDone,
   input wire txCollision,
   input wire txDeferral,
   input wire rxFrameEnd,
   input wire [10:0] rxLength,
   input wire rxIsControl,
   input wire rxErr,
   output reg gasketOutputA,
   output reg gasketOutputB,
   output reg duplexOut,
   output reg fullDuplexMode,
   output reg speed1000Mode,
   output reg ifResetOut,
   output reg macResetOut,
   output reg shortGapTx,
   output reg obeyPause,
   output reg forceCollision,
   output reg sendPause,
   output reg pauseTimerWrEn,
   output wire txStartGrant,
   output reg paceHold,
   output reg rxKeep,
   output reg rxFlagControl,
   output reg rxFlagFragment,
   output reg rxFlagUndersize,
   output reg rxFlagOversize,
   output reg rxFlagJabber,
   output reg rxFlagError
);
   // ==========================================
   // register state
   reg [31:0] ctrl_q;
   reg idle_q;
   reg softRst_q;
   reg [10:0] maxLen_q;
   reg [4:0] pace_q;
   reg [9:0] rnd_q;
   reg [3:0] coll_q;
   reg [9:0] backoff_q;
   reg [15:0] slot_q;
   reg [2:0] gapCnt_q;
   wire wrEn = psel & penable & pwrite & clkEn;
   wire manufacturing_test = ctrl_q[`B_MANUFACTURING_TEST];
   wire selGig = ctrl_q[`B_PINSEL] ? speedSelectInput : ctrl_q[`B_GIG];
   wire speed_1000_select = selGig | ctrl_q[`B_FGIG];
   wire selDup = ctrl_q[`B_PINSEL] ? duplexIn : ctrl_q[`B_FDX];
   wire fdx = selDup | speed_1000_select | ctrl_q[`B_LOOP];
   wire flowAct = ctrl_q[`B_RXFL] & rxFlowTrigger;
   wire txFlowAct = pauseActive & fdx & ctrl_q[`B_TXFL];
   // mask follows the tally including this collision, so the first retry draws 0 or 1
   wire [3:0] collNext = (coll_q == 4'hf) ? 4'hf : coll_q + 4'h1;
   wire [9:0] mask = (collNext >= `BACKOFF_LIMIT) ? 10'h3ff :
      ((10'h001 << collNext) - 10'h001);
   wire [31:0] slotLast = SLOT_CYCLES - 1;

   // apb always answers in the access cycle; no wait states
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   // pause period blocks new non-pause starts, running frame untouched
   assign txStartGrant = txStartReq & ~paceHold & (txIsPause | ~txFlowAct);

   // ==========================================
   // register writes and soft reset
   always @(posedge core_clk) begin
      if (rst) begin
         ctrl_q <= 32'h00000000;
         idle_q <= 1'b0;
         softRst_q <= 1'b0;
         maxLen_q <= `MAXLEN_RST;
      end else if (clkEn) begin
         if (softRst_q) begin
            // one cycle of mac reset, then the bit reads back as done
            ctrl_q <= 32'h00000000;
            idle_q <= 1'b0;
            maxLen_q <= `MAXLEN_RST;
            softRst_q <= 1'b0;
         end else begin
            if (wrEn && paddr == `OFS_CONTROL)
               ctrl_q <= pwdata & `CTRL_MASK;
            if (wrEn && paddr == `OFS_SOFTRST && pwdata[0])
               softRst_q <= 1'b1;
            if (wrEn && paddr == `OFS_MAXLEN)
               maxLen_q <= pwdata[10:0];
            // idle flag follows the command once the mac has quiesced
            idle_q <= ctrl_q[`B_IDLE] & (idle_q | (macIdleAck & ~txBusy));
         end
      end
   end

   // ==========================================
   // backoff, pacing, random generator
   always @(posedge core_clk) begin
      if (rst || softRst_q) begin
         rnd_q <= 10'h000;
         pace_q <= 5'h00;
         coll_q <= 4'h0;
         backoff_q <= 10'h000;
         slot_q <= 16'h0000;
         gapCnt_q <= 3'h0;
      end else if (clkEn) begin
         // free-running counter; test writes override it
         if (wrEn && paddr == `OFS_BOFF && manufacturing_test)
            rnd_q <= pwdata[`RND_HI:`RND_LO];
         else
            rnd_q <= rnd_q + 10'h001;
         if (wrEn && paddr == `OFS_BOFF && manufacturing_test)
            pace_q <= pwdata[`PACE_HI:`PACE_LO];
         else if (txCollision || txDeferral)
            pace_q <= `PACE_LOAD;
         else if (txDone && pace_q != 5'h00)
            pace_q <= pace_q - 5'h01;
         // collisions of the current frame, cleared when it completes
         if (txDone)
            coll_q <= 4'h0;
         else if (txCollision && coll_q != 4'hf)
            coll_q <= coll_q + 4'h1;
         if (txCollision) begin
            backoff_q <= rnd_q & mask;
            slot_q <= 16'h0000;
         end else if (backoff_q != 10'h000) begin
            if (slot_q == slotLast[15:0]) begin
               slot_q <= 16'h0000;
               backoff_q <= backoff_q - 10'h001;
            end else
               slot_q <= slot_q + 16'h0001;
         end
         // pacing spaces new frames by four gaps after a clean frame
         if (txDone && !txCollision && !txDeferral && pace_q != 5'h00 && ctrl_q[`B_PACE])
            gapCnt_q <= `PACE_GAPS;
         else if (gapCnt_q != 3'h0 && !txBusy)
            gapCnt_q <= gapCnt_q - 3'h1;
      end
   end

   // ==========================================
   // mode outputs, registered
   always @(posedge core_clk) begin
      if (rst) begin
         gasketOutputA <= 1'b0;
         gasketOutputB <= 1'b0;
         duplexOut <= 1'b0;
         fullDuplexMode <= 1'b0;
         speed1000Mode <= 1'b0;
         ifResetOut <= 1'b1;
         macResetOut <= 1'b1;
         shortGapTx <= 1'b0;
         obeyPause <= 1'b0;
         forceCollision <= 1'b0;
         sendPause <= 1'b0;
         pauseTimerWrEn <= 1'b0;
         paceHold <= 1'b0;
      end else if (clkEn) begin
         gasketOutputA <= ctrl_q[`B_IFA];
         gasketOutputB <= ctrl_q[`B_IFB];
         duplexOut <= ctrl_q[`B_FDX];
         fullDuplexMode <= fdx;
         speed1000Mode <= speed_1000_select;
         ifResetOut <= ~ctrl_q[`B_IFEN] | softRst_q;
         macResetOut <= softRst_q;
         shortGapTx <= ctrl_q[`B_SGAP] & shortGapIn;
         obeyPause <= fdx & ctrl_q[`B_TXFL] & pauseFrameRx;
         forceCollision <= flowAct & ~fdx;
         sendPause <= flowAct & fdx;
         pauseTimerWrEn <= pauseTimerWrite & manufacturing_test;
         paceHold <= (gapCnt_q != 3'h0);
      end
   end

   // ==========================================
   // receive frame filter, evaluated at frame end
   always @(posedge core_clk) begin
      if (rst || !ctrl_q[`B_IFEN]) begin
         rxKeep <= 1'b0;
         rxFlagControl <= 1'b0;
         rxFlagFragment <= 1'b0;
         rxFlagUndersize <= 1'b0;
         rxFlagOversize <= 1'b0;
         rxFlagJabber <= 1'b0;
         rxFlagError <= 1'b0;
      end else if (clkEn) begin
         rxFlagControl <= rxFrameEnd & rxIsControl & ctrl_q[`B_CMF];
         rxFlagFragment <= rxFrameEnd & (rxLength < `MIN_FRAME) & rxErr;
         rxFlagUndersize <= rxFrameEnd & (rxLength < `MIN_FRAME) & ~rxErr;
         rxFlagOversize <= rxFrameEnd & (rxLength > maxLen_q) & ~rxErr;
         rxFlagJabber <= rxFrameEnd & (rxLength > maxLen_q) & rxErr;
         rxFlagError <= rxFrameEnd & rxErr & ctrl_q[`B_CEF];
         rxKeep <= rxFrameEnd & (~rxIsControl | ctrl_q[`B_CMF])
            & ((rxLength >= `MIN_FRAME) | ctrl_q[`B_CSF])
            & (~rxErr | ctrl_q[`B_CEF]);
      end
   end

   // ==========================================
   // read mux, unmapped addresses read zero
   always @* begin
      prdata = 32'h00000000;
      case (paddr)
         `OFS_CONTROL: prdata = ctrl_q;
         `OFS_STATUS: begin
            prdata[`S_IDLE] = idle_q;
            prdata[`S_EXTGIG] = externalSpeedState;
            prdata[`S_EXTFDX] = externalDuplexState;
            prdata[`S_RXFA] = flowAct;
            prdata[`S_TXFA] = txFlowAct;
         end
         `OFS_SOFTRST: prdata[0] = softRst_q;
         `OFS_MAXLEN: prdata[10:0] = maxLen_q;
         `OFS_BOFF: begin
            prdata[`PACE_HI:`PACE_LO] = pace_q;
            prdata[`RND_HI:`RND_LO] = rnd_q;
            prdata[`COLL_HI:`COLL_LO] = coll_q;
            prdata[`BO_HI:`BO_LO] = backoff_q;
         end
         default: prdata = 32'h00000000;
      endcase
   end
endmodule // mac_ctrl_status

// ==== verif/mac_ctrl_monitor.sv ====
`timescale 1ns/100ps
`include "mac_ctrl_consts.vh"
module mac_ctrl_monitor (
   input wire core_clk,
   input wire rst,
   input wire clkEn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire externalSpeedState,
   input wire externalDuplexState,
   input wire shortGapIn,
   input wire txStartReq,
   input wire txIsPause,
   input wire rxFrameEnd,
   input wire rxErr,
   input wire gasketOutputA,
   input wire gasketOutputB,
   input wire duplexOut,
   input wire fullDuplexMode,
   input wire speed1000Mode,
   input wire ifResetOut,
   input wire macResetOut,
   input wire shortGapTx,
   input wire txStartGrant,
   input wire rxFlagJabber
);
   // ======
   // decoded transfers
   wire acc = psel && penable && clkEn;
   wire wc = acc && pwrite && paddr == `OFS_CONTROL;
   wire rs = acc && !pwrite && paddr == `OFS_STATUS;
   wire ws = acc && pwrite && paddr == `OFS_SOFTRST && pwdata[0];
   // ======
   // port relations; pins lag the control edge by one register stage
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   gasket_a_out_a: assert property (wc |-> ##2 gasketOutputA == $past(pwdata[15], 2))
      else $error("gasket a pin wrong");
   gasket_b_out_a: assert property (wc |-> ##2 gasketOutputB == $past(pwdata[16], 2))
      else $error("gasket b pin wrong");
   duplex_pin_a: assert property (wc |-> ##2 duplexOut == $past(pwdata[0], 2))
      else $error("duplex pin wrong");
   if_reset_a: assert property (wc |-> ##2 ifResetOut == !$past(pwdata[5], 2))
      else $error("interface reset wrong");
   status_ext_a: assert property (rs |-> prdata[4:3] == {externalSpeedState,
      externalDuplexState})
      else $error("external state bits wrong");
   gig_full_a: assert property (speed1000Mode |-> fullDuplexMode)
      else $error("gigabit without full duplex");
   pause_block_a: assert property (rs && prdata[0] && txStartReq && !txIsPause |->
      !txStartGrant)
      else $error("start granted in pause");
   short_gap_a: assert property (shortGapTx |-> $past(shortGapIn))
      else $error("short gap without request");
   jabber_a: assert property (rxFlagJabber |-> $past(rxFrameEnd && rxErr))
      else $error("jabber without errored frame");
   soft_reset_a: assert property (ws |-> ##[1:2] macResetOut)
      else $error("soft reset not issued");
   // a few scenarios worth seeing reached
   cover property (wc ##2 !ifResetOut);
   cover property (rxFlagJabber);
   cover property (txStartReq && !txStartGrant);
endmodule // mac_ctrl_monitor

// ==== verif/phy_model.sv ====
`timescale 1ns/100ps
module phy_model (
   input wire core_clk,
   input wire rst,
   input wire gasketOutputA,
   input wire gasketOutputB,
   output reg externalSpeedState,
   output reg externalDuplexState
);
   // ======
   // gasket straps settle one clock later into the reported link state
   always @(posedge core_clk) begin
      externalDuplexState <= rst ? 1'b0 : gasketOutputA;
      externalSpeedState <= rst ? 1'b0 : gasketOutputB;
   end
endmodule // phy_model

// ==== verif/tb_gigabit_mac_control_status.sv ====
`timescale 1ns/100ps
`include "mac_ctrl_consts.vh"
module tb_gigabit_mac_control_status;
   // ======
   // stimulus and observed signals
   logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, shortGapIn = 0;
   logic macIdleAck = 0, rxFlowTrigger = 0, pauseActive = 0, txStartReq = 0, txIsPause = 0;
   logic txDone = 0, txCollision = 0, txDeferral = 0, rxFrameEnd = 0, rxIsControl = 0;
   logic rxErr = 0, duplexIn = 0, speedSelectInput = 0, pauseFrameRx = 0, pauseTimerWrite = 0;
   logic [10:0] rxLength = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rv, r1;
   wire [31:0] prdata;
   wire pready, pslverr, gasketOutputA, gasketOutputB, duplexOut, fullDuplexMode;
   wire speed1000Mode, ifResetOut, macResetOut, shortGapTx, obeyPause, forceCollision;
   wire sendPause, pauseTimerWrEn, txStartGrant, paceHold, rxKeep, rxFlagControl;
   wire rxFlagFragment, rxFlagUndersize, rxFlagOversize, rxFlagJabber, rxFlagError;
   wire externalSpeedState, externalDuplexState;
   integer fails = 0, checked = 0;
   // ======
   // clock and units; slot time shortened to keep the run brief
   initial forever #5 core_clk = ~core_clk;
   mac_ctrl_status #(.SLOT_CYCLES(4)) uut (.core_clk, .rst, .clkEn(1'b1), .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .duplexIn, .speedSelectInput,
      .externalSpeedState, .externalDuplexState, .shortGapIn, .macIdleAck, .rxFlowTrigger,
      .pauseFrameRx, .pauseActive, .pauseTimerWrite, .txStartReq, .txIsPause,
      .txBusy(1'b0), .txDone, .txCollision, .txDeferral, .rxFrameEnd, .rxLength,
      .rxIsControl, .rxErr, .gasketOutputA, .gasketOutputB, .duplexOut, .fullDuplexMode,
      .speed1000Mode, .ifResetOut, .macResetOut, .shortGapTx, .obeyPause, .forceCollision,
      .sendPause, .pauseTimerWrEn, .txStartGrant, .paceHold, .rxKeep, .rxFlagControl,
      .rxFlagFragment, .rxFlagUndersize, .rxFlagOversize, .rxFlagJabber, .rxFlagError);
   phy_model far (.core_clk, .rst, .gasketOutputA, .gasketOutputB, .externalSpeedState,
      .externalDuplexState);
   // ======
   // shared tasks
   task stop_test;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, s, e);
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge core_clk);
   endtask
   // apb transfer; two idle edges after, so registered outputs have settled on return
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      integer i;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1;
      i = 0;
      do begin
         @(posedge core_clk);
         i++;
      end while (pready !== 1'b1 && i < 16);
      rv = prdata;
      psel <= 0;
      penable <= 0;
      if (pready !== 1'b1) begin
         fails++;
         stop_test;
      end
      cyc(2);
   endtask
   // one received frame; verdict pulses are judged at the next rising edge, before they clear
   task rxc(input logic [31:0] c, input logic [10:0] n, input logic k, input logic er,
      input logic [6:0] e, input logic [6:0] m);
      xfer(1, `OFS_CONTROL, c);
      rxLength <= n;
      rxIsControl <= k;
      rxErr <= er;
      rxFrameEnd <= 1;
      @(posedge core_clk);
      rxFrameEnd <= 0;
      @(posedge core_clk);
      chk({rxKeep, rxFlagControl, rxFlagFragment, rxFlagUndersize, rxFlagOversize,
         rxFlagJabber, rxFlagError} & m, e & m);
   endtask
   // transmit event pulse {done, deferral, collision}, then read the backoff word
   task ev(input logic [2:0] v);
      {txDone, txDeferral, txCollision} <= v;
      @(posedge core_clk);
      {txDone, txDeferral, txCollision} <= 3'h0;
      cyc(2);
      chk(paceHold, v[2]);
      xfer(0, `OFS_BOFF, 0);
   endtask
   // ======
   // scenarios
   task t_modes;
      logic [31:0] c [6];
      logic [1:0] e [6];
      // loopback entered and left with the interface held in reset
      c = '{32'h2, 32'h0, 32'h21, 32'ha0, 32'h20020, 32'h40020};
      e = '{2'h1, 2'h0, 2'h1, 2'h3, 2'h3, 2'h1};
      duplexIn <= 1;
      for (int k = 0; k < 6; k++) begin
         xfer(1, `OFS_CONTROL, c[k]);
         chk({speed1000Mode, fullDuplexMode}, e[k]);
      end
      xfer(1, `OFS_CONTROL, 32'h18021);
      chk({gasketOutputB, gasketOutputA, duplexOut, ifResetOut}, 4'he);
      xfer(1, `OFS_CONTROL, 32'hfffffffd);
      xfer(0, `OFS_CONTROL, 0);
      chk(rv, `CTRL_MASK & 32'hfffffffd);
      $display("modes test done");
   endtask
   task t_flow;
      logic [31:0] c [3];
      logic [2:0] e [3];
      c = '{32'h8029, 32'h8028, 32'h8020};
      e = '{3'h6, 3'h5, 3'h0};
      rxFlowTrigger <= 1;
      for (int k = 0; k < 3; k++) begin
         xfer(1, `OFS_CONTROL, c[k]);
         cyc(2);
         xfer(0, `OFS_STATUS, 0);
         chk({rv[4:1], sendPause, forceCollision}, {3'h2, e[k]});
      end
      xfer(1, `OFS_CONTROL, 32'h31);
      pauseActive <= 1;
      txStartReq <= 1;
      pauseFrameRx <= 1;
      pauseTimerWrite <= 1;
      xfer(0, `OFS_STATUS, 0);
      chk({rv[0], txStartGrant}, 2'h2);
      chk({obeyPause, pauseTimerWrEn}, 2'h2);
      txIsPause <= 1;
      cyc(1);
      chk(txStartGrant, 1);
      xfer(1, `OFS_CONTROL, 32'h20);
      xfer(0, `OFS_STATUS, 0);
      chk(rv[0], 0);
      chk(obeyPause, 0);
      $display("flow test done");
   endtask
   task t_rx;
      rxc(32'h20, 11'd100, 0, 0, 7'h40, 7'h7f);
      rxc(32'h0, 11'd100, 0, 0, 7'h00, 7'h40);
      rxc(32'h20, 11'd10, 0, 0, 7'h00, 7'h40);
      rxc(32'h800020, 11'd10, 0, 0, 7'h48, 7'h7f);
      rxc(32'hc00020, 11'd10, 0, 1, 7'h50, 7'h58);
      rxc(32'h20, 11'd200, 0, 1, 7'h00, 7'h40);
      rxc(32'h400020, 11'd200, 0, 1, 7'h41, 7'h7f);
      rxc(32'h400020, 11'd1518, 0, 0, 7'h40, 7'h46);
      rxc(32'h400020, 11'd1519, 0, 0, 7'h44, 7'h46);
      rxc(32'h400020, 11'd1519, 0, 1, 7'h42, 7'h46);
      rxc(32'h20, 11'd100, 1, 0, 7'h00, 7'h40);
      rxc(32'h1000020, 11'd100, 1, 0, 7'h60, 7'h7f);
      xfer(1, `OFS_MAXLEN, 32'h64);
      rxc(32'h400020, 11'd101, 0, 0, 7'h44, 7'h46);
      $display("receive test done");
   endtask
   task t_boff;
      xfer(1, `OFS_BOFF, 32'h7c000000);
      xfer(0, `OFS_BOFF, 0);
      chk(rv[30:26], 0);
      xfer(1, `OFS_CONTROL, 32'h64);
      chk(pauseTimerWrEn, 1);
      xfer(1, `OFS_BOFF, 32'h7c000000);
      xfer(0, `OFS_BOFF, 0);
      r1 = rv;
      chk(rv[30:26], 5'h1f);
      ev(3'h4);
      chk({rv[30:26], rv[25:16] !== r1[25:16]}, 6'h3d);
      ev(3'h2);
      chk(rv[30:26], 5'h1f);
      ev(3'h1);
      chk({rv[15:12], rv[9:0] < 10'h2}, 5'h3);
      ev(3'h4);
      chk(rv[15:12], 0);
      $display("backoff test done");
   endtask
   task t_idle;
      integer i;
      macIdleAck <= 1;
      shortGapIn <= 1;
      xfer(1, `OFS_CONTROL, 32'h8c21);
      cyc(2);
      xfer(0, `OFS_STATUS, 0);
      chk({rv[31], shortGapTx}, 2'h3);
      xfer(1, `OFS_SOFTRST, 1);
      chk(macResetOut, 1);
      i = 0;
      do begin
         xfer(0, `OFS_SOFTRST, 0);
         i++;
      end while (rv[0] && i < 8);
      chk(rv[0], 0);
      xfer(0, `OFS_CONTROL, 0);
      chk(rv, 0);
      xfer(0, `OFS_MAXLEN, 0);
      chk(shortGapTx, 0);
      chk(rv, 32'h5ee);
      $display("idle and soft reset test done");
   endtask
   // ======
   // main sequence and hang guard
   initial begin
      cyc(8);
      rst <= 0;
      @(posedge core_clk);
      xfer(1, 12'h0fc, 32'h1);
      xfer(0, `OFS_MAXLEN, 0);
      chk(ifResetOut, 1);
      chk(rv, 32'h5ee);
      t_modes;
      t_flow;
      t_rx;
      t_boff;
      t_idle;
      stop_test;
   end
   initial begin
      cyc(20000);
      fails++;
      stop_test;
   end
endmodule // tb_gigabit_mac_control_status
bind mac_ctrl_status mac_ctrl_monitor mon (.core_clk, .rst, .clkEn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .externalSpeedState, .externalDuplexState, .shortGapIn,
   .txStartReq, .txIsPause, .rxFrameEnd, .rxErr, .gasketOutputA, .gasketOutputB, .duplexOut,
   .fullDuplexMode, .speed1000Mode, .ifResetOut, .macResetOut, .shortGapTx, .txStartGrant,
   .rxFlagJabber);
